//--- rtl/itv_pkg.sv
// itv_pkg: constants, types and register map of the interrupt and trap vectoring block.
// assumes a single 40 MHz system clock and a 32-bit ahb-lite register bus.
package itv_pkg;

  // ---------------------------------------------------------------
  // program memory vector area
  // ---------------------------------------------------------------
  localparam logic [23:0] ITV_VEC_AREA_LO   = 24'h000000;
  localparam logic [23:0] ITV_VEC_AREA_HI   = 24'h000200;
  localparam logic [23:0] ITV_RESET_ADDR    = 24'h000000;
  localparam logic [23:0] ITV_RESET_TARGET  = 24'h000002;
  localparam logic [23:0] ITV_PRI_BASE      = 24'h000004;
  localparam logic [23:0] ITV_PRI_END       = 24'h0000FF;
  localparam logic [23:0] ITV_ALT_END       = 24'h0001FF;
  localparam logic [23:0] ITV_ALT_OFFSET    = 24'h000100;
  localparam logic [6:0]  ITV_IRQ_OFFSET    = 7'h08;

  // ---------------------------------------------------------------
  // vector numbers
  // ---------------------------------------------------------------
  localparam logic [6:0] ITV_VEC_OSC_FAIL   = 7'h01;
  localparam logic [6:0] ITV_VEC_ADDR_ERR   = 7'h02;
  localparam logic [6:0] ITV_VEC_STACK_ERR  = 7'h03;
  localparam logic [6:0] ITV_VEC_MATH_ERR   = 7'h04;
  localparam logic [6:0] ITV_VEC_DMA_ERR    = 7'h05;
  localparam logic [6:0] ITV_VEC_NUM_TRAPS  = 7'h08;
  localparam logic [6:0] ITV_VEC_DMA4       = 7'h36;
  localparam logic [6:0] ITV_VEC_TIMER6     = 7'h37;
  localparam logic [6:0] ITV_VEC_TIMER7     = 7'h38;
  localparam logic [6:0] ITV_VEC_TW2_SLAVE  = 7'h39;
  localparam logic [6:0] ITV_VEC_TW2_MASTER = 7'h3A;
  localparam logic [6:0] ITV_VEC_TIMER8     = 7'h3B;
  localparam logic [6:0] ITV_VEC_TIMER9     = 7'h3C;
  localparam logic [6:0] ITV_VEC_EXT3       = 7'h3D;
  localparam logic [6:0] ITV_VEC_EXT4       = 7'h3E;
  localparam logic [6:0] ITV_VEC_CAN2_RX    = 7'h3F;
  localparam logic [6:0] ITV_VEC_CAN2_EVT   = 7'h40;
  localparam logic [6:0] ITV_VEC_CODEC_ERR  = 7'h43;
  localparam logic [6:0] ITV_VEC_CODEC_DONE = 7'h44;
  localparam logic [6:0] ITV_VEC_DMA5       = 7'h45;
  localparam logic [6:0] ITV_VEC_SER1_ERR   = 7'h49;
  localparam logic [6:0] ITV_VEC_SER2_ERR   = 7'h4A;
  localparam logic [6:0] ITV_VEC_DMA6       = 7'h4C;
  localparam logic [6:0] ITV_VEC_DMA7       = 7'h4D;
  localparam logic [6:0] ITV_VEC_CAN1_TX    = 7'h4E;
  localparam logic [6:0] ITV_VEC_CAN2_TX    = 7'h4F;
  localparam logic [6:0] ITV_VEC_RSV_LO     = 7'h50;
  localparam logic [6:0] ITV_VEC_RSV_HI     = 7'h7D;

  localparam int ITV_NSRC = 27;            // 5 traps + 20 peripheral sources + 2 unused slots
  localparam int ITV_NTRAP = 5;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ITV_REG_PRIORITY = 8'h00;  // compare_capture_priority
  localparam logic [7:0] ITV_REG_CONTROL  = 8'h04;  // bit0 alternate table select
  localparam logic [7:0] ITV_REG_PENDING  = 8'h08;  // pending_vector_code, ro
  localparam logic [7:0] ITV_REG_STATUS   = 8'h0C;  // sticky source flags, ro
  localparam logic [7:0] ITV_REG_CLEAR    = 8'h10;  // write one to clear, wo
  localparam logic [7:0] ITV_REG_ENABLE   = 8'h14;  // interrupt enable

  // priority field positions
  localparam int ITV_POS_COMPARE7 = 12;
  localparam int ITV_POS_COMPARE6 = 8;
  localparam int ITV_POS_COMPARE5 = 4;
  localparam int ITV_POS_CAPTURE6 = 0;
  localparam logic [2:0]  ITV_PRIO_RESET  = 3'h4;
  localparam logic [2:0]  ITV_PRIO_OFF    = 3'h0;
  localparam logic [15:0] ITV_PRIORITY_RESET = 16'h4444;
  localparam logic [15:0] ITV_PRIORITY_MASK  = 16'h7777;

  // ahb-lite encodings
  localparam logic [1:0] ITV_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] ITV_HSIZE_WORD    = 3'h2;

  // one vector request handed to the cpu
  typedef struct packed {
    logic        valid;
    logic [6:0]  vector;
    logic [6:0]  irq;
    logic [23:0] address;
  } itv_fetch_s;

endpackage

//--- rtl/itv_vec_addr.sv
// itv_vec_addr: maps a vector number to its program memory word address.
// assumes the vector number is already validated by the caller.
`timescale 1ns/1ps
`default_nettype none
module itv_vec_addr
  import itv_pkg::*;
(
  input  wire logic [6:0]  vector,
  input  wire logic        alt_sel,
  output logic      [23:0] address,
  output logic      [6:0]  irq
);

  // ---------------------------------------------------------------
  // address arithmetic
  // ---------------------------------------------------------------
  logic [23:0] pri_addr;

  // one program word per vector, two address units each
  assign pri_addr = ITV_PRI_BASE + {16'h0000, vector, 1'b0};
  assign address  = alt_sel ? (pri_addr + ITV_ALT_OFFSET) : pri_addr;
  // request number is the vector less eight; traps have no request number
  assign irq      = (vector >= ITV_IRQ_OFFSET) ? (vector - ITV_IRQ_OFFSET) : 7'h00;

endmodule
`default_nettype wire

//--- rtl/itv_top.sv
// itv_top: interrupt and trap vectoring with priority register and ahb-lite slave.
// assumes the cpu core takes a fetch request whenever fetch_ack is high, and that
// source inputs are single-cycle event pulses from logic on sys_clk.
//
// Implementation choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - vector area below 0x200 is reserved
// - reset starts fetch at zero, target next
// - primary and alternate vector tables exist
// - vector address is base plus twice number
// - request number equals vector minus eight
// - traps one to five on first entries
// - dma channels four to seven fixed vectors
// - can vectors 63, 64, 78, 79
// - codec 67, 68; serial errors 73, 74
// - timers, external inputs fixed; 80-125 reserved
// - three-bit priority, zero disables source; here zero only blocks the fetch, irq_out still rises
// - priority fields reset to binary 100
// - pending code is vector minus eight
module itv_top
  import itv_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // event sources: traps [4:0], then peripherals in table order
  input  wire logic [ITV_NSRC-1:0]   src_event,
  // vector fetch towards the cpu core
  input  wire logic                  fetch_ack,
  output itv_fetch_s                 fetch,
  output logic      [23:0]           reset_fetch_addr,
  output logic      [23:0]           reset_target_addr,
  output logic                       irq_out
);

  // ---------------------------------------------------------------
  // source to vector map
  // ---------------------------------------------------------------
  localparam logic [6:0] SRC_VEC [ITV_NSRC] = '{
    ITV_VEC_OSC_FAIL, ITV_VEC_ADDR_ERR, ITV_VEC_STACK_ERR,
    ITV_VEC_MATH_ERR, ITV_VEC_DMA_ERR,
    ITV_VEC_DMA4, ITV_VEC_TIMER6, ITV_VEC_TIMER7,
    ITV_VEC_TW2_SLAVE, ITV_VEC_TW2_MASTER, ITV_VEC_TIMER8,
    ITV_VEC_TIMER9, ITV_VEC_EXT3, ITV_VEC_EXT4,
    ITV_VEC_CAN2_RX, ITV_VEC_CAN2_EVT,
    ITV_VEC_CODEC_ERR, ITV_VEC_CODEC_DONE, ITV_VEC_DMA5,
    ITV_VEC_SER1_ERR, ITV_VEC_SER2_ERR, ITV_VEC_DMA6, ITV_VEC_DMA7,
    ITV_VEC_CAN1_TX, ITV_VEC_CAN2_TX,
    ITV_VEC_CAN2_TX, ITV_VEC_CAN2_TX
  };
  // the last two slots alias a real vector and are masked out of status by used_mask
  localparam int NUSED = 25;

  // the reset vector pair is fixed; nothing here may be relocated
  assign reset_fetch_addr  = ITV_RESET_ADDR;
  assign reset_target_addr = ITV_RESET_TARGET;

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [15:0]         priority_reg;
  logic                alt_table;
  logic [ITV_NSRC-1:0] status;
  logic [ITV_NSRC-1:0] enable;
  logic [6:0]          pending_vector_code;

  logic                dp_valid;
  logic                dp_write;
  logic [7:0]          dp_addr;

  wire logic [2:0] compare7_priority = priority_reg[ITV_POS_COMPARE7 +: 3];
  wire logic [2:0] compare6_priority = priority_reg[ITV_POS_COMPARE6 +: 3];
  wire logic [2:0] compare5_priority = priority_reg[ITV_POS_COMPARE5 +: 3];
  wire logic [2:0] capture6_priority = priority_reg[ITV_POS_CAPTURE6 +: 3];

  // ---------------------------------------------------------------
  // ahb-lite address phase capture
  // ---------------------------------------------------------------
  logic addr_take;
  assign addr_take = hsel && hready && (htrans == ITV_HTRANS_NONSEQ);

  // the slave never stalls; every access answers in its data phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end else if (hready) begin
      dp_valid <= addr_take;
      dp_write <= hwrite;
      dp_addr  <= haddr[7:0];
    end
  end

  logic wr_en;
  assign wr_en = dp_valid && dp_write;

  // ---------------------------------------------------------------
  // priority and control registers
  // ---------------------------------------------------------------
  // unimplemented bits 15, 11, 7, 3 are masked on write so they read zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      priority_reg <= ITV_PRIORITY_RESET;
    end else if (wr_en && dp_addr == ITV_REG_PRIORITY) begin
      priority_reg <= hwdata[15:0] & ITV_PRIORITY_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      alt_table <= 1'b0;
      enable    <= '0;
    end else if (wr_en) begin
      if (dp_addr == ITV_REG_CONTROL) begin
        alt_table <= hwdata[0];
      end
      if (dp_addr == ITV_REG_ENABLE) begin
        enable <= hwdata[ITV_NSRC-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // sticky status flags
  // ---------------------------------------------------------------
  logic [ITV_NSRC-1:0] clr_mask;
  logic [ITV_NSRC-1:0] taken_mask;
  logic [ITV_NSRC-1:0] used_mask;

  assign used_mask = {{(ITV_NSRC-NUSED){1'b0}}, {NUSED{1'b1}}};
  assign clr_mask  = (wr_en && dp_addr == ITV_REG_CLEAR) ? hwdata[ITV_NSRC-1:0] : '0;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      status <= '0;
    end else begin
      status <= ((status & ~clr_mask & ~taken_mask) | src_event) & used_mask;
    end
  end

  assign irq_out = |(status & enable);

  // ---------------------------------------------------------------
  // arbitration: traps first, then highest priority, then lowest vector
  // ---------------------------------------------------------------
  // only four peripheral sources have programmable levels; the rest sit at the
  // reset default so that the table stays small
  function automatic logic [2:0] src_level(input int idx, input logic [15:0] pr);
    logic [2:0] lvl;
    lvl = ITV_PRIO_RESET;
    if (idx < ITV_NTRAP) begin
      lvl = 3'h7;
    end else if (idx == 6) begin
      lvl = pr[ITV_POS_COMPARE7 +: 3];
    end else if (idx == 7) begin
      lvl = pr[ITV_POS_COMPARE6 +: 3];
    end else if (idx == 10) begin
      lvl = pr[ITV_POS_COMPARE5 +: 3];
    end else if (idx == 11) begin
      lvl = pr[ITV_POS_CAPTURE6 +: 3];
    end
    return lvl;
  endfunction

  logic [4:0] win_idx;
  logic       win_any;
  logic [2:0] win_lvl;

  always_comb begin
    win_idx = 5'h00;
    win_any = 1'b0;
    win_lvl = ITV_PRIO_OFF;
    for (int i = 0; i < ITV_NSRC; i++) begin
      // level zero never competes; traps ignore the enable register
      if (status[i] && (enable[i] || i < ITV_NTRAP) &&
          src_level(i, priority_reg) != ITV_PRIO_OFF &&
          (!win_any || src_level(i, priority_reg) > win_lvl)) begin
        win_any = 1'b1;
        win_idx = 5'(i);
        win_lvl = src_level(i, priority_reg);
      end
    end
  end

  // ---------------------------------------------------------------
  // fetch request towards the cpu
  // ---------------------------------------------------------------
  logic [6:0]  win_vec;
  logic [23:0] win_addr;
  logic [6:0]  win_irq;
  logic [4:0]  fetch_idx;  // source behind the standing request

  assign win_vec = SRC_VEC[win_idx];

  itv_vec_addr u_vec_addr (
    .vector  (win_vec),
    .alt_sel (alt_table),
    .address (win_addr),
    .irq     (win_irq)
  );

  always_comb begin
    taken_mask = '0;
    if (fetch.valid && fetch_ack) begin
      // clear the source the cpu really took; the live winner may be newer
      taken_mask[fetch_idx] = 1'b1;
    end
  end

  // the fetch output is a registered copy of the current winner
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fetch               <= '0;
      pending_vector_code <= 7'h00;
      fetch_idx           <= 5'h00;
    end else begin
      fetch.valid   <= win_any && !(fetch.valid && fetch_ack);
      fetch.vector  <= win_vec;
      fetch.irq     <= win_irq;
      fetch.address <= win_addr;
      fetch_idx     <= win_idx;
      pending_vector_code <= win_any ? (win_vec - ITV_IRQ_OFFSET) : 7'h00;
    end
  end

  // ---------------------------------------------------------------
  // register read mux
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hrdata <= 32'h00000000;
    end else if (addr_take && !hwrite) begin
      unique case (haddr[7:0])
        ITV_REG_PRIORITY: hrdata <= {16'h0000, priority_reg};
        ITV_REG_CONTROL:  hrdata <= {31'h00000000, alt_table};
        ITV_REG_PENDING:  hrdata <= {25'h0000000, pending_vector_code};
        ITV_REG_STATUS:   hrdata <= {{(32-ITV_NSRC){1'b0}}, status};
        ITV_REG_ENABLE:   hrdata <= {{(32-ITV_NSRC){1'b0}}, enable};
        default:          hrdata <= 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_addr_in_area;
    @(posedge sys_clk) disable iff (srst)
      fetch.valid |-> (fetch.address >= ITV_PRI_BASE && fetch.address < ITV_VEC_AREA_HI);
  endproperty
  a_addr_in_area: assert property (p_addr_in_area) else $error("vector outside area");

  property p_alt_offset;
    @(posedge sys_clk) disable iff (srst)
      fetch.valid && $past(alt_table) |-> fetch.address > ITV_PRI_END && fetch.address <= ITV_ALT_END;
  endproperty
  a_alt_offset: assert property (p_alt_offset) else $error("alternate table address wrong");

  property p_addr_formula;
    @(posedge sys_clk) disable iff (srst)
      fetch.valid && !$past(alt_table) |->
        fetch.address == ITV_PRI_BASE + {16'h0000, fetch.vector, 1'b0};
  endproperty
  a_addr_formula: assert property (p_addr_formula) else $error("primary address mismatch");

  property p_irq_minus8;
    @(posedge sys_clk) disable iff (srst)
      fetch.valid && fetch.vector >= ITV_VEC_NUM_TRAPS |-> fetch.irq == fetch.vector - ITV_IRQ_OFFSET;
  endproperty
  a_irq_minus8: assert property (p_irq_minus8) else $error("irq number mismatch");

  property p_prio_reset;
    @(posedge sys_clk) $fell(srst) |-> priority_reg == ITV_PRIORITY_RESET;
  endproperty
  a_prio_reset: assert property (p_prio_reset) else $error("priority reset value wrong");

  property p_prio_holes;
    @(posedge sys_clk) disable iff (srst)
      (priority_reg & ~ITV_PRIORITY_MASK) == 16'h0000;
  endproperty
  a_prio_holes: assert property (p_prio_holes) else $error("reserved priority bit set");

  property p_disabled_src;
    @(posedge sys_clk) disable iff (srst)
      win_any && win_idx >= ITV_NTRAP |-> win_lvl != ITV_PRIO_OFF;
  endproperty
  a_disabled_src: assert property (p_disabled_src) else $error("level zero source won");

  property p_code_vec;
    @(posedge sys_clk) disable iff (srst)
      fetch.valid |-> pending_vector_code == 7'(fetch.vector - ITV_IRQ_OFFSET);
  endproperty
  a_code_vec: assert property (p_code_vec) else $error("pending code mismatch");

  property p_not_reserved;
    @(posedge sys_clk) disable iff (srst)
      fetch.valid |-> !(fetch.vector >= ITV_VEC_RSV_LO && fetch.vector <= ITV_VEC_RSV_HI);
  endproperty
  a_not_reserved: assert property (p_not_reserved) else $error("reserved vector fetched");

  property p_trap_first;
    @(posedge sys_clk) disable iff (srst)
      status[0] |-> !win_any || win_idx < 5'(ITV_NTRAP);
  endproperty
  a_trap_first: assert property (p_trap_first) else $error("trap lost arbitration");

  // a programmable source whose field read zero when it won must never be fetched
  property p_compare7_level;
    @(posedge sys_clk) disable iff (srst)
      fetch.valid && fetch.vector == ITV_VEC_TIMER6 |-> $past(compare7_priority) != ITV_PRIO_OFF;
  endproperty
  a_compare7_level: assert property (p_compare7_level) else $error("compare7 level zero fetched");

  property p_compare6_level;
    @(posedge sys_clk) disable iff (srst)
      fetch.valid && fetch.vector == ITV_VEC_TIMER7 |-> $past(compare6_priority) != ITV_PRIO_OFF;
  endproperty
  a_compare6_level: assert property (p_compare6_level) else $error("compare6 level zero fetched");

  property p_compare5_level;
    @(posedge sys_clk) disable iff (srst)
      fetch.valid && fetch.vector == ITV_VEC_TIMER8 |-> $past(compare5_priority) != ITV_PRIO_OFF;
  endproperty
  a_compare5_level: assert property (p_compare5_level) else $error("compare5 level zero fetched");

  property p_capture6_level;
    @(posedge sys_clk) disable iff (srst)
      fetch.valid && fetch.vector == ITV_VEC_TIMER9 |-> $past(capture6_priority) != ITV_PRIO_OFF;
  endproperty
  a_capture6_level: assert property (p_capture6_level) else $error("capture6 level zero fetched");

endmodule
`default_nettype wire

//--- tb/itv_cpu_model.sv
// itv_cpu_model: behavioural cpu core that takes vector fetches from the block.
// assumes fetch is registered on sys_clk and fetch_ack is sampled at rising edges.
`timescale 1ns/1ps
`default_nettype none
module itv_cpu_model
  import itv_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        stall,
  input  wire itv_fetch_s  fetch,
  output logic             fetch_ack,
  output logic      [15:0] taken,
  output var itv_fetch_s   last
);
  // -------------------------------------------------------------
  // fetch handshake
  // -------------------------------------------------------------
  // ack follows valid one edge late, so stall gives a slow core; the request is
  // taken at the edge where ack and valid are both high
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fetch_ack <= 1'b0;
      taken     <= 16'h0;
      last      <= '0;
    end else if (fetch_ack && fetch.valid) begin
      last      <= fetch;
      taken     <= taken + 16'h1;
      fetch_ack <= 1'b0;
    end else begin
      fetch_ack <= fetch.valid && !stall;  // ack dropped when valid goes away
    end
  end
endmodule
`default_nettype wire

//--- tb/interrupt_trap_vectoring_tb_top.sv
// interrupt_trap_vectoring_tb_top: register and vector fetch tests of itv_top.
// assumes a 40 MHz sys_clk, synchronous reset and a zero-wait ahb-lite slave.
`timescale 1ns/1ps
`default_nettype none
module interrupt_trap_vectoring_tb_top
  import itv_pkg::*;
;
  logic                sys_clk;
  logic                srst;
  logic                hsel;
  logic                hwrite;
  logic                stall;
  logic                fetch_ack;
  logic                hreadyout;
  logic                hresp;
  logic                irq_out;
  logic [31:0]         haddr;
  logic [31:0]         hwdata;
  logic [31:0]         hrdata;
  logic [31:0]         rd;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic [ITV_NSRC-1:0] src_event;
  logic [23:0]         rst_fetch;
  logic [23:0]         rst_target;
  logic [15:0]         taken;
  itv_fetch_s          fetch;
  itv_fetch_s          last;
  int                  failures;
  int                  checked;
  int                  cycles;
  int                  n;
  // peripheral vectors in source order, bits 5 to 24
  localparam logic [6:0] PVEC [20] = '{7'h36, 7'h37, 7'h38, 7'h39, 7'h3A, 7'h3B, 7'h3C, 7'h3D, 7'h3E, 7'h3F,
                                       7'h40, 7'h43, 7'h44, 7'h45, 7'h49, 7'h4A, 7'h4C, 7'h4D, 7'h4E, 7'h4F};

  // -------------------------------------------------------------
  // design and core model
  // -------------------------------------------------------------
  itv_top dut (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .src_event(src_event), .fetch_ack(fetch_ack), .fetch(fetch), .reset_fetch_addr(rst_fetch),
    .reset_target_addr(rst_target), .irq_out(irq_out));
  itv_cpu_model cpu (.sys_clk(sys_clk), .srst(srst), .stall(stall), .fetch(fetch), .fetch_ack(fetch_ack),
    .taken(taken), .last(last));

  // -------------------------------------------------------------
  // clock and timeout
  // -------------------------------------------------------------
  // free running clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // a hung handshake ends the run well above the expected few hundred cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task automatic complete_run();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp, input string m);
    cmp_word({31'h0, got}, {31'h0, exp}, m);
  endtask
  // one single ahb-lite transfer; read data taken at the data phase edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= ITV_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= ITV_HSIZE_WORD;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd_cmp(input logic [7:0] a, input logic [31:0] exp, input string m);
    bus(1'b0, a, 32'h0, rd);
    cmp_word(rd, exp, m);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask
  task automatic pulse(input logic [ITV_NSRC-1:0] m, input logic hold);
    @(posedge sys_clk);
    src_event <= m;
    stall     <= hold;
    @(posedge sys_clk);
    src_event <= '0;
  endtask
  task automatic wait_fetch(input int k);
    if (stall === 1'b1) begin
      @(posedge sys_clk);
      stall <= 1'b0;
    end
    for (int i = 0; i < 40 && taken !== 16'(k); i++) begin
      @(posedge sys_clk);
      #1;
    end
    cmp_word(32'(taken), 32'(k), "fetch count");
  endtask
  task automatic cmp_fetch(input logic [6:0] v, input logic [6:0] q, input logic [23:0] base);
    cmp_word(32'(last.vector), 32'(v), "vector");
    cmp_word(32'(last.irq), 32'(q), "irq number");
    cmp_word(32'(last.address), 32'(base + 24'(v) * 2), "address");
    cmp_bit(last.address < 24'h000200, 1'b1, "vector area");
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    {srst, hsel, hwrite, stall} = 4'h8;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h0;
    src_event = '0;
    n = 0;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    // reset values, unmapped place and reset vector pair
    rd_cmp(ITV_REG_PRIORITY, 32'h0000_4444, "priority reset");
    rd_cmp(ITV_REG_CONTROL, 32'h0, "control reset");
    rd_cmp(ITV_REG_ENABLE, 32'h0, "enable reset");
    rd_cmp(ITV_REG_STATUS, 32'h0, "status reset");
    rd_cmp(ITV_REG_PENDING, 32'h0, "pending reset");
    rd_cmp(8'h40, 32'h0, "unmapped read");
    cmp_word({8'h0, rst_fetch}, 32'h0, "reset fetch");
    cmp_word({8'h0, rst_target}, 32'h2, "reset target");
    cmp_bit(hresp, 1'b0, "response");
    cmp_bit(hreadyout, 1'b1, "ready");
    $display("test reset done");
    // field layout: unimplemented bits stay zero
    wr(ITV_REG_PRIORITY, 32'hFFFF_FFFF);
    rd_cmp(ITV_REG_PRIORITY, 32'h0000_7777, "priority fields");
    wr(ITV_REG_PRIORITY, 32'h0000_4444);
    $display("test fields done");
    // traps reach the cpu with enable still clear
    for (int t = 0; t < ITV_NTRAP; t++) begin
      pulse(ITV_NSRC'(1) << t, 1'b0);
      wait_fetch(++n);
      cmp_fetch(7'(t + 1), 7'h0, ITV_PRI_BASE);
    end
    $display("test traps done");
    // every peripheral through both tables
    wr(ITV_REG_ENABLE, 32'h01FF_FFE0);
    for (int a = 0; a < 2; a++) begin
      wr(ITV_REG_CONTROL, 32'(a));
      for (int i = 0; i < 20; i++) begin
        pulse(ITV_NSRC'(1) << (i + 5), 1'b1);
        rd_cmp(ITV_REG_PENDING, 32'(PVEC[i] - 7'h08), "pending");
        wait_fetch(++n);
        cmp_fetch(PVEC[i], PVEC[i] - 7'h08, (a == 1) ? 24'h000104 : 24'h000004);
      end
    end
    $display("test vectors done");
    // sticky status, masked and enabled interrupt, clear
    wr(ITV_REG_CONTROL, 32'h0);
    wr(ITV_REG_ENABLE, 32'h0);
    pulse(ITV_NSRC'(1) << 11, 1'b1);
    wr(ITV_REG_STATUS, 32'hFFFF_FFFF);
    rd_cmp(ITV_REG_STATUS, 32'h0000_0800, "status sticky");
    cmp_bit(irq_out, 1'b0, "irq masked");
    cmp_bit(fetch.valid, 1'b0, "no fetch masked");
    wr(ITV_REG_ENABLE, 32'h0000_0800);
    @(posedge sys_clk);
    #1;
    cmp_bit(irq_out, 1'b1, "irq enabled");
    wr(ITV_REG_CLEAR, 32'h0000_0800);
    rd_cmp(ITV_REG_STATUS, 32'h0, "status cleared");
    rd_cmp(ITV_REG_CLEAR, 32'h0, "clear reads zero");
    cmp_bit(irq_out, 1'b0, "irq cleared");
    stall <= 1'b0;
    repeat (10) @(posedge sys_clk);
    cmp_word(32'(taken), 32'(n), "no fetch after clear");
    $display("test interrupt done");
    // priority order and level zero
    wr(ITV_REG_ENABLE, 32'h01FF_FFE0);
    wr(ITV_REG_PRIORITY, 32'h0000_1744);
    pulse(ITV_NSRC'(3) << 6, 1'b1);
    rd_cmp(ITV_REG_PENDING, 32'h30, "highest pending");
    wait_fetch(++n);
    cmp_word(32'(last.vector), 32'h38, "first by priority");
    wait_fetch(++n);
    cmp_word(32'(last.vector), 32'h37, "second by priority");
    wr(ITV_REG_PRIORITY, 32'h0000_0744);
    pulse(ITV_NSRC'(1) << 6, 1'b0);
    repeat (10) @(posedge sys_clk);
    cmp_word(32'(taken), 32'(n), "level zero blocked");
    $display("test priority done");
    // reset in mid-run brings back the defaults and drops the pending interrupt
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    rd_cmp(ITV_REG_PRIORITY, 32'h0000_4444, "priority after reset");
    rd_cmp(ITV_REG_STATUS, 32'h0, "status after reset");
    cmp_bit(irq_out, 1'b0, "irq after reset");
    $display("test mid reset done");
    complete_run();
  end
endmodule
`default_nettype wire
